// [design/aload_consts.svh]
// Purpose: Opcode patterns and clock counts for the arithmetic/logic decoder
// Assumes: Counts are processor clocks; ranges are held at their upper figure
// Notes: Definitions only
`ifndef ALOAD_CONSTS_SVH
`define ALOAD_CONSTS_SVH

// Opcode patterns, compared against the whole opcode byte or its upper bits
`define ALOAD_OPC_GRP_F6 7'h7B
`define ALOAD_OPC_SPROD_IMM 6'h1A
`define ALOAD_OPC_BCD_PROD 8'hD4
`define ALOAD_OPC_BCD_DIV 8'hD5
`define ALOAD_OPC_BCD_BASE 8'h0A
`define ALOAD_OPC_SEXT_B 8'h98
`define ALOAD_OPC_SEXT_W 8'h99
`define ALOAD_OPC_SHIFT1 7'h68
`define ALOAD_OPC_SHIFTC 7'h69
`define ALOAD_OPC_SHIFTI 7'h60
`define ALOAD_OPC_AND_RM 6'h08
`define ALOAD_OPC_GRP_80 7'h40
`define ALOAD_OPC_AND_ACC 7'h12
`define ALOAD_OPC_TEST_RM 7'h42
`define ALOAD_OPC_TEST_ACC 7'h54
`define ALOAD_OPC_OR_RM 6'h02
`define ALOAD_OPC_OR_ACC 7'h06

// Sub-opcode values of the group opcodes
`define ALOAD_SUB_TEST 3'h0
`define ALOAD_SUB_UPROD 3'h4
`define ALOAD_SUB_SPROD 3'h5
`define ALOAD_SUB_UQUOT 3'h6
`define ALOAD_SUB_SQUOT 3'h7
`define ALOAD_SUB_AND 3'h4
`define ALOAD_SUB_OR 3'h1

// Shift/rotate operation field values
`define ALOAD_SHF_ROTATE_LEFT 3'h0
`define ALOAD_SHF_ROTATE_RIGHT 3'h1
`define ALOAD_SHF_ROTATE_CARRY_LEFT 3'h2
`define ALOAD_SHF_ROTATE_CARRY_RIGHT 3'h3
`define ALOAD_SHF_SHIFT_LEFT 3'h4
`define ALOAD_SHF_SHIFT_RIGHT_LOGICAL 3'h5
`define ALOAD_SHF_UNASSIGNED 3'h6
`define ALOAD_SHF_SHIFT_RIGHT_ARITHMETIC 3'h7

// Clock counts: R/M = register/memory, B/W = byte/word
`define ALOAD_CYC_UPROD_RB 9'h01C
`define ALOAD_CYC_UPROD_RW 9'h025
`define ALOAD_CYC_UPROD_MB 9'h022
`define ALOAD_CYC_UPROD_MW 9'h02B
`define ALOAD_CYC_SPROD_RB 9'h01C
`define ALOAD_CYC_SPROD_RW 9'h025
`define ALOAD_CYC_SPROD_MB 9'h022
`define ALOAD_CYC_SPROD_MW 9'h02B
`define ALOAD_CYC_SPROD_IMM_R 9'h019
`define ALOAD_CYC_SPROD_IMM_M 9'h020
`define ALOAD_CYC_UQUOT_RB 9'h01D
`define ALOAD_CYC_UQUOT_RW 9'h026
`define ALOAD_CYC_UQUOT_MB 9'h023
`define ALOAD_CYC_UQUOT_MW 9'h02C
`define ALOAD_CYC_SQUOT_RB 9'h034
`define ALOAD_CYC_SQUOT_RW 9'h03D
`define ALOAD_CYC_SQUOT_MB 9'h03A
`define ALOAD_CYC_SQUOT_MW 9'h043
`define ALOAD_CYC_BCD_PROD 9'h013
`define ALOAD_CYC_BCD_DIV 9'h00F
`define ALOAD_CYC_SEXT_B 9'h002
`define ALOAD_CYC_SEXT_W 9'h004
`define ALOAD_CYC_SHIFT1_R 9'h002
`define ALOAD_CYC_SHIFT1_M 9'h00F
`define ALOAD_CYC_SHIFTN_R 9'h005
`define ALOAD_CYC_SHIFTN_M 9'h011
`define ALOAD_CYC_LOGIC_RM_R 9'h003
`define ALOAD_CYC_LOGIC_RM_M 9'h00A
`define ALOAD_CYC_LOGIC_IMM_R 9'h004
`define ALOAD_CYC_LOGIC_IMM_M 9'h010
`define ALOAD_CYC_TEST_IMM_R 9'h004
`define ALOAD_CYC_TEST_IMM_M 9'h00A
`define ALOAD_CYC_ACC_B 9'h003
`define ALOAD_CYC_ACC_W 9'h004
`define ALOAD_CYC_NARROW_WORD 9'h004

`endif

// [design/aload_pkg.sv]
// Purpose: Types shared by the arithmetic/logic decoder
// Assumes: Nothing beyond the constants header
// Notes: Instruction kinds double as the OP_KIND output code
package aload_pkg;

  // Decoded instruction kinds; the GRP kinds wait for the ModR/M byte
  typedef enum logic [4:0] {
    K_NONE, K_GRP_F6, K_GRP_80,
    K_UPROD, K_SPROD, K_SPROD_IMM, K_UQUOT, K_SQUOT,
    K_BCD_PROD, K_BCD_DIV, K_SEXT_B, K_SEXT_W,
    K_SHIFT1, K_SHIFTC, K_SHIFTI,
    K_AND_RM, K_AND_IMM, K_AND_ACC,
    K_TEST_RM, K_TEST_IMM, K_TEST_ACC,
    K_OR_RM, K_OR_IMM, K_OR_ACC
  } aload_kind_t;

  // Fetch and execute states
  typedef enum logic [2:0] {
    S_OPCODE, S_MODRM, S_DISP, S_IMM, S_BCD2, S_EXEC
  } aload_state_t;

endpackage

// [design/aload_tmr_if.sv]
// Purpose: Carrier between decoder control and its execution timer
// Assumes: Single clock domain
// Notes: load is the instruction's clock count minus one
interface aload_tmr_if;
  logic start;
  logic [8:0] load;
  logic expire;
  modport ctrl (output start, output load, input expire);
  modport tmr (input start, input load, output expire);
endinterface

// [design/aload_timer.sv]
// Purpose: Down counter that marks the last clock of an instruction
// Assumes: load is at least one when start is high
// Notes: expire is high for one cycle, load cycles after start
module aload_timer (
  input wire logic clk,
  input wire logic rst,
  aload_tmr_if.tmr bus
);
  logic [8:0] cnt_r;

  // Count down to zero; a new start always wins over the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 9'h000;
    end else if (bus.start) begin
      cnt_r <= bus.load;
    end else if (cnt_r != 9'h000) begin
      cnt_r <= cnt_r - 9'h001;
    end
  end

  // Last counted cycle
  assign bus.expire = (cnt_r == 9'h001);
endmodule // aload_timer

// [design/aload_decode.sv]
// Purpose: Decode and time the multiply/divide, BCD, sign-extend, shift and AND/TEST/OR forms
// Assumes: Instruction bytes arrive from fetch logic on CLOCK; NARROW_BUS is an external pin
// Notes: Ranged clock counts are held at their upper figure
`include "aload_consts.svh"

module aload_decode (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  input wire logic [7:0] COUNT_LOW,
  input wire logic NARROW_BUS,
  output logic BYTE_READY,
  output logic BUSY,
  output logic DONE,
  output logic ILLEGAL,
  output logic [4:0] OP_KIND,
  output logic [2:0] OP_FIELD,
  output logic OP_WIDE,
  output logic OP_MEM,
  output logic OP_DIR,
  output logic OP_SEXT,
  output logic FLAGS_ONLY,
  output logic [15:0] IMM_VALUE,
  output logic [7:0] SHIFT_COUNT,
  output logic [8:0] CYCLES
);

  // Displacement bytes implied by a ModR/M byte
  function automatic logic [1:0] disp_len(input logic [7:0] m);
    logic [1:0] r;
    r = 2'h0;
    case (m[7:6])
      2'h0: r = (m[2:0] == 3'h6) ? 2'h2 : 2'h0;
      2'h1: r = 2'h1;
      2'h2: r = 2'h2;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // Immediate bytes that follow ModR/M and displacement
  function automatic logic [1:0] imm_len(input aload_pkg::aload_kind_t k, input logic w,
                                         input logic s);
    logic [1:0] r;
    r = 2'h0;
    case (k)
      aload_pkg::K_SPROD_IMM: r = s ? 2'h1 : 2'h2;
      aload_pkg::K_AND_IMM, aload_pkg::K_OR_IMM, aload_pkg::K_TEST_IMM,
      aload_pkg::K_AND_ACC, aload_pkg::K_OR_ACC, aload_pkg::K_TEST_ACC:
        r = w ? 2'h2 : 2'h1;
      aload_pkg::K_SHIFTI: r = 2'h1;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // Clock count of one instruction
  function automatic logic [8:0] cycles(input aload_pkg::aload_kind_t k, input logic m,
                                        input logic w, input logic [7:0] n, input logic nb);
    logic [8:0] c;
    c = `ALOAD_CYC_SEXT_B;
    case (k)
      aload_pkg::K_UPROD: c = m ? (w ? `ALOAD_CYC_UPROD_MW : `ALOAD_CYC_UPROD_MB)
                                : (w ? `ALOAD_CYC_UPROD_RW : `ALOAD_CYC_UPROD_RB);
      aload_pkg::K_SPROD: c = m ? (w ? `ALOAD_CYC_SPROD_MW : `ALOAD_CYC_SPROD_MB)
                                : (w ? `ALOAD_CYC_SPROD_RW : `ALOAD_CYC_SPROD_RB);
      aload_pkg::K_SPROD_IMM: c = m ? `ALOAD_CYC_SPROD_IMM_M : `ALOAD_CYC_SPROD_IMM_R;
      aload_pkg::K_UQUOT: c = m ? (w ? `ALOAD_CYC_UQUOT_MW : `ALOAD_CYC_UQUOT_MB)
                                : (w ? `ALOAD_CYC_UQUOT_RW : `ALOAD_CYC_UQUOT_RB);
      aload_pkg::K_SQUOT: c = m ? (w ? `ALOAD_CYC_SQUOT_MW : `ALOAD_CYC_SQUOT_MB)
                                : (w ? `ALOAD_CYC_SQUOT_RW : `ALOAD_CYC_SQUOT_RB);
      aload_pkg::K_BCD_PROD: c = `ALOAD_CYC_BCD_PROD;
      aload_pkg::K_BCD_DIV: c = `ALOAD_CYC_BCD_DIV;
      aload_pkg::K_SEXT_B: c = `ALOAD_CYC_SEXT_B;
      aload_pkg::K_SEXT_W: c = `ALOAD_CYC_SEXT_W;
      aload_pkg::K_SHIFT1: c = m ? `ALOAD_CYC_SHIFT1_M : `ALOAD_CYC_SHIFT1_R;
      aload_pkg::K_SHIFTC, aload_pkg::K_SHIFTI:
        c = (m ? `ALOAD_CYC_SHIFTN_M : `ALOAD_CYC_SHIFTN_R) + {1'b0, n};
      aload_pkg::K_AND_RM, aload_pkg::K_OR_RM, aload_pkg::K_TEST_RM:
        c = m ? `ALOAD_CYC_LOGIC_RM_M : `ALOAD_CYC_LOGIC_RM_R;
      aload_pkg::K_AND_IMM, aload_pkg::K_OR_IMM:
        c = m ? `ALOAD_CYC_LOGIC_IMM_M : `ALOAD_CYC_LOGIC_IMM_R;
      aload_pkg::K_TEST_IMM: c = m ? `ALOAD_CYC_TEST_IMM_M : `ALOAD_CYC_TEST_IMM_R;
      aload_pkg::K_AND_ACC, aload_pkg::K_OR_ACC, aload_pkg::K_TEST_ACC:
        c = w ? `ALOAD_CYC_ACC_W : `ALOAD_CYC_ACC_B;
      default: c = `ALOAD_CYC_SEXT_B;
    endcase
    if (m && w && nb) begin
      c = c + `ALOAD_CYC_NARROW_WORD;
    end
    return c;
  endfunction

  aload_pkg::aload_state_t state_r, state_nxt;
  aload_pkg::aload_kind_t kind_r, op_kind, grp_kind, modrm_kind, kind_now;
  logic ready_r, busy_r, done_r, illegal_r;
  logic narrow_s1_r, narrow_s2_r;
  logic wide_r, dir_r, mem_r, imm_got_r;
  logic [2:0] field_r;
  logic [1:0] disp_left_r, imm_left_r;
  logic [15:0] imm_r, imm_nxt;
  logic take, start, bad, modrm_bad, mem_now, wide_now, is_acc, is_shift;
  logic [1:0] disp_w, imm_w;
  logic [7:0] n_now;
  logic [8:0] cyc_now;
  logic [4:0] op_kind_r;
  logic [2:0] op_field_r;
  logic op_wide_r, op_mem_r, op_dir_r, op_sext_r, flags_only_r;
  logic [15:0] imm_value_r;
  logic [7:0] shift_count_r;
  logic [8:0] cycles_r;
  aload_tmr_if tmr_if ();

  // Pin synchroniser; only the second stage is read
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      narrow_s1_r <= 1'b0;
      narrow_s2_r <= 1'b0;
    end else begin
      narrow_s1_r <= NARROW_BUS;
      narrow_s2_r <= narrow_s1_r;
    end
  end

  assign take = BYTE_VALID && ready_r;
  assign op_kind =
    (BYTE_DATA[7:1] == `ALOAD_OPC_GRP_F6) ? aload_pkg::K_GRP_F6 :
    (BYTE_DATA[7:2] == `ALOAD_OPC_SPROD_IMM && BYTE_DATA[0]) ? aload_pkg::K_SPROD_IMM :
    (BYTE_DATA == `ALOAD_OPC_BCD_PROD) ? aload_pkg::K_BCD_PROD :
    (BYTE_DATA == `ALOAD_OPC_BCD_DIV) ? aload_pkg::K_BCD_DIV :
    (BYTE_DATA == `ALOAD_OPC_SEXT_B) ? aload_pkg::K_SEXT_B :
    (BYTE_DATA == `ALOAD_OPC_SEXT_W) ? aload_pkg::K_SEXT_W :
    (BYTE_DATA[7:1] == `ALOAD_OPC_SHIFT1) ? aload_pkg::K_SHIFT1 :
    (BYTE_DATA[7:1] == `ALOAD_OPC_SHIFTC) ? aload_pkg::K_SHIFTC :
    (BYTE_DATA[7:1] == `ALOAD_OPC_SHIFTI) ? aload_pkg::K_SHIFTI :
    (BYTE_DATA[7:2] == `ALOAD_OPC_AND_RM) ? aload_pkg::K_AND_RM :
    (BYTE_DATA[7:1] == `ALOAD_OPC_GRP_80) ? aload_pkg::K_GRP_80 :
    (BYTE_DATA[7:1] == `ALOAD_OPC_AND_ACC) ? aload_pkg::K_AND_ACC :
    (BYTE_DATA[7:1] == `ALOAD_OPC_TEST_RM) ? aload_pkg::K_TEST_RM :
    (BYTE_DATA[7:1] == `ALOAD_OPC_TEST_ACC) ? aload_pkg::K_TEST_ACC :
    (BYTE_DATA[7:2] == `ALOAD_OPC_OR_RM) ? aload_pkg::K_OR_RM :
    (BYTE_DATA[7:1] == `ALOAD_OPC_OR_ACC) ? aload_pkg::K_OR_ACC : aload_pkg::K_NONE;

  assign grp_kind = (kind_r == aload_pkg::K_GRP_F6) ?
    ((BYTE_DATA[5:3] == `ALOAD_SUB_TEST) ? aload_pkg::K_TEST_IMM :
     (BYTE_DATA[5:3] == `ALOAD_SUB_UPROD) ? aload_pkg::K_UPROD :
     (BYTE_DATA[5:3] == `ALOAD_SUB_SPROD) ? aload_pkg::K_SPROD :
     (BYTE_DATA[5:3] == `ALOAD_SUB_UQUOT) ? aload_pkg::K_UQUOT :
     (BYTE_DATA[5:3] == `ALOAD_SUB_SQUOT) ? aload_pkg::K_SQUOT : aload_pkg::K_NONE) :
    ((BYTE_DATA[5:3] == `ALOAD_SUB_AND) ? aload_pkg::K_AND_IMM :
     (BYTE_DATA[5:3] == `ALOAD_SUB_OR) ? aload_pkg::K_OR_IMM : aload_pkg::K_NONE);
  assign modrm_kind = (kind_r == aload_pkg::K_GRP_F6 || kind_r == aload_pkg::K_GRP_80) ?
                      grp_kind : kind_r;
  assign is_shift = (kind_r == aload_pkg::K_SHIFT1 || kind_r == aload_pkg::K_SHIFTC ||
                     kind_r == aload_pkg::K_SHIFTI);
  assign modrm_bad = (modrm_kind == aload_pkg::K_NONE) ||
                     (is_shift && BYTE_DATA[5:3] == `ALOAD_SHF_UNASSIGNED);
  assign is_acc = (op_kind == aload_pkg::K_AND_ACC || op_kind == aload_pkg::K_OR_ACC ||
                   op_kind == aload_pkg::K_TEST_ACC);
  assign disp_w = disp_len(BYTE_DATA);
  assign imm_w = imm_len(modrm_kind, wide_r, dir_r);

  // Operands as seen in the cycle that starts execution
  assign kind_now = (state_r == aload_pkg::S_OPCODE) ? op_kind :
                    (state_r == aload_pkg::S_MODRM) ? modrm_kind : kind_r;
  assign mem_now = (state_r == aload_pkg::S_MODRM) ? (BYTE_DATA[7:6] != 2'h3) :
                   (state_r == aload_pkg::S_OPCODE) ? 1'b0 : mem_r;
  assign wide_now = (state_r == aload_pkg::S_OPCODE) ? BYTE_DATA[0] : wide_r;
  // count source: immediate byte or count_register_low
  assign n_now = (kind_r == aload_pkg::K_SHIFTI) ? BYTE_DATA : COUNT_LOW;
  assign cyc_now = cycles(kind_now, mem_now, wide_now, n_now, narrow_s2_r);
  // Low byte first; a lone signed byte of the multiply is sign-extended
  assign imm_nxt = imm_got_r ? {BYTE_DATA, imm_r[7:0]} :
                   (kind_r == aload_pkg::K_SPROD_IMM && dir_r) ?
                   {{8{BYTE_DATA[7]}}, BYTE_DATA} : {8'h00, BYTE_DATA};

  // Fetch sequencer
  always_comb begin
    state_nxt = state_r;
    start = 1'b0;
    bad = 1'b0;
    case (state_r)
      aload_pkg::S_OPCODE: if (take) begin
        if (op_kind == aload_pkg::K_NONE) begin
          bad = 1'b1;
        end else if (op_kind == aload_pkg::K_SEXT_B || op_kind == aload_pkg::K_SEXT_W) begin
          start = 1'b1;
          state_nxt = aload_pkg::S_EXEC;
        end else if (op_kind == aload_pkg::K_BCD_PROD || op_kind == aload_pkg::K_BCD_DIV) begin
          state_nxt = aload_pkg::S_BCD2;
        end else if (is_acc) begin
          state_nxt = aload_pkg::S_IMM;
        end else begin
          state_nxt = aload_pkg::S_MODRM;
        end
      end
      aload_pkg::S_MODRM: if (take) begin
        if (modrm_bad) begin
          bad = 1'b1;
          state_nxt = aload_pkg::S_OPCODE;
        end else if (disp_w != 2'h0) begin
          state_nxt = aload_pkg::S_DISP;
        end else if (imm_w != 2'h0) begin
          state_nxt = aload_pkg::S_IMM;
        end else begin
          start = 1'b1;
          state_nxt = aload_pkg::S_EXEC;
        end
      end
      aload_pkg::S_DISP: if (take && disp_left_r == 2'h1) begin
        if (imm_left_r != 2'h0) begin
          state_nxt = aload_pkg::S_IMM;
        end else begin
          start = 1'b1;
          state_nxt = aload_pkg::S_EXEC;
        end
      end
      aload_pkg::S_IMM: if (take && imm_left_r == 2'h1) begin
        start = 1'b1;
        state_nxt = aload_pkg::S_EXEC;
      end
      // second byte must be the decimal base
      aload_pkg::S_BCD2: if (take) begin
        start = (BYTE_DATA == `ALOAD_OPC_BCD_BASE);
        bad = !start;
        state_nxt = start ? aload_pkg::S_EXEC : aload_pkg::S_OPCODE;
      end
      aload_pkg::S_EXEC: if (tmr_if.expire) begin
        state_nxt = aload_pkg::S_OPCODE;
      end
      default: state_nxt = aload_pkg::S_OPCODE;
    endcase
  end

  assign tmr_if.start = start;
  assign tmr_if.load = cyc_now - 9'h001;

  aload_timer u_timer (
    .clk(CLOCK),
    .rst(RST),
    .bus(tmr_if.tmr)
  );

  // Control and handshake state
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r <= aload_pkg::S_OPCODE;
      ready_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt != aload_pkg::S_EXEC);
      busy_r <= (state_nxt != aload_pkg::S_OPCODE);
      done_r <= tmr_if.expire;
      illegal_r <= bad;
    end
  end

  // Fields gathered while the bytes arrive
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      kind_r <= aload_pkg::K_NONE;
      wide_r <= 1'b0;
      dir_r <= 1'b0;
      mem_r <= 1'b0;
      field_r <= 3'h0;
      disp_left_r <= 2'h0;
      imm_left_r <= 2'h0;
      imm_got_r <= 1'b0;
      imm_r <= 16'h0000;
    end else if (take && state_r == aload_pkg::S_OPCODE) begin
      kind_r <= op_kind;
      wide_r <= BYTE_DATA[0];
      dir_r <= BYTE_DATA[1];
      mem_r <= 1'b0;
      field_r <= 3'h0;
      disp_left_r <= 2'h0;
      imm_left_r <= is_acc ? (BYTE_DATA[0] ? 2'h2 : 2'h1) : 2'h0;
      imm_got_r <= 1'b0;
      imm_r <= 16'h0000;
    end else if (take && state_r == aload_pkg::S_MODRM) begin
      kind_r <= modrm_kind;
      mem_r <= (BYTE_DATA[7:6] != 2'h3);
      field_r <= BYTE_DATA[5:3];
      disp_left_r <= disp_w;
      imm_left_r <= imm_w;
    end else if (take && state_r == aload_pkg::S_DISP) begin
      disp_left_r <= disp_left_r - 2'h1;
    end else if (take && state_r == aload_pkg::S_IMM) begin
      imm_left_r <= imm_left_r - 2'h1;
      imm_got_r <= 1'b1;
      imm_r <= imm_nxt;
    end
  end

  // Decoded result, latched as execution starts
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      op_kind_r <= 5'h00;
      op_field_r <= 3'h0;
      op_wide_r <= 1'b0;
      op_mem_r <= 1'b0;
      op_dir_r <= 1'b0;
      op_sext_r <= 1'b0;
      flags_only_r <= 1'b0;
      imm_value_r <= 16'h0000;
      shift_count_r <= 8'h00;
      cycles_r <= 9'h000;
    end else if (start) begin
      op_kind_r <= kind_now;
      op_field_r <= (state_r == aload_pkg::S_MODRM) ? BYTE_DATA[5:3] : field_r;
      op_wide_r <= wide_now;
      op_mem_r <= mem_now;
      op_dir_r <= (state_r == aload_pkg::S_OPCODE) ? BYTE_DATA[1] : dir_r;
      op_sext_r <= (kind_now == aload_pkg::K_SPROD_IMM) && dir_r;
      flags_only_r <= (kind_now == aload_pkg::K_TEST_RM || kind_now == aload_pkg::K_TEST_IMM ||
                       kind_now == aload_pkg::K_TEST_ACC);
      imm_value_r <= (state_r == aload_pkg::S_IMM) ? imm_nxt : imm_r;
      shift_count_r <= (kind_now == aload_pkg::K_SHIFT1) ? 8'h01 :
                       (kind_now == aload_pkg::K_SHIFTC || kind_now == aload_pkg::K_SHIFTI) ?
                       n_now : 8'h00;
      cycles_r <= cyc_now;
    end
  end

  // Outputs straight from flip-flops
  assign BYTE_READY = ready_r;
  assign BUSY = busy_r;
  assign DONE = done_r;
  assign ILLEGAL = illegal_r;
  assign OP_KIND = op_kind_r;
  assign OP_FIELD = op_field_r;
  assign OP_WIDE = op_wide_r;
  assign OP_MEM = op_mem_r;
  assign OP_DIR = op_dir_r;
  assign OP_SEXT = op_sext_r;
  assign FLAGS_ONLY = flags_only_r;
  assign IMM_VALUE = imm_value_r;
  assign SHIFT_COUNT = shift_count_r;
  assign CYCLES = cycles_r;

  // Checks on timing and decode
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_start_reg(aload_pkg::aload_kind_t k);
    start && kind_now == k && !mem_now;
  endsequence
  sequence s_done_pulse;
    done_r ##1 !done_r;
  endsequence

  property p_sext_byte;
    s_start_reg(aload_pkg::K_SEXT_B) |-> ##2 s_done_pulse;
  endproperty
  a_sext_byte: assert property (p_sext_byte) else $error("byte extend not 2 clocks");
  property p_sext_word;
    s_start_reg(aload_pkg::K_SEXT_W) |=> !done_r[*3] ##1 done_r;
  endproperty
  a_sext_word: assert property (p_sext_word) else $error("word extend not 4 clocks");
  property p_bcd_prod;
    s_start_reg(aload_pkg::K_BCD_PROD) |-> ##19 s_done_pulse;
  endproperty
  a_bcd_prod: assert property (p_bcd_prod) else $error("adjust after multiply wrong");
  property p_bcd_div;
    s_start_reg(aload_pkg::K_BCD_DIV) |=> busy_r[*8] ##7 done_r;
  endproperty
  a_bcd_div: assert property (p_bcd_div) else $error("adjust before divide wrong");
  property p_shift_one;
    s_start_reg(aload_pkg::K_SHIFT1) |-> ##2 done_r && shift_count_r == 8'h01;
  endproperty
  a_shift_one: assert property (p_shift_one) else $error("shift by one not 2 clocks");
  property p_unassigned;
    state_r == aload_pkg::S_MODRM && take && is_shift && BYTE_DATA[5:3] == 3'h6
      |=> illegal_r && state_r == aload_pkg::S_OPCODE && !busy_r;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("field 110 accepted");
  property p_uquot_byte;
    s_start_reg(aload_pkg::K_UQUOT) ##0 !wide_now |=> cycles_r == 9'h01D;
  endproperty
  a_uquot_byte: assert property (p_uquot_byte) else $error("divide byte count wrong");
  property p_test_flags;
    $rose(done_r) && op_kind_r == aload_pkg::K_TEST_IMM |-> flags_only_r;
  endproperty
  a_test_flags: assert property (p_test_flags) else $error("test not flags only");
  property p_narrow_word;
    start && kind_now == aload_pkg::K_AND_IMM && mem_now && wide_now && narrow_s2_r
      |=> cycles_r == 9'h014;
  endproperty
  a_narrow_word: assert property (p_narrow_word) else $error("narrow penalty missing");
endmodule // aload_decode

// [tb/aload_decode_tb.sv]
// Purpose: Self-checking bench for the arithmetic/logic opcode decoder
// Assumes: Kind codes follow the enum order; ranged counts use the upper figure
// Notes: Driver queues one note per instruction; monitor pops it on DONE or ILLEGAL
module aload_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [4:0] k; logic [8:0] c; logic [16:0] im; int t; logic [16:0] xs;} aload_exp_t;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic BYTE_VALID = 1'b0;
  logic [7:0] BYTE_DATA = 8'h00;
  logic [7:0] COUNT_LOW = 8'h00;
  logic NARROW_BUS = 1'b0;
  wire BYTE_READY, BUSY, DONE, ILLEGAL, OP_WIDE, OP_MEM, OP_DIR, OP_SEXT, FLAGS_ONLY;
  wire [4:0] OP_KIND;
  wire [2:0] OP_FIELD;
  wire [15:0] IMM_VALUE;
  wire [7:0] SHIFT_COUNT;
  wire [8:0] CYCLES;
  aload_exp_t q[$];
  aload_exp_t e;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  int t_take;
  int n;
  logic [16:0] x;
  aload_decode dut_u (.CLOCK(CLOCK), .RST(RST), .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA),
    .COUNT_LOW(COUNT_LOW), .NARROW_BUS(NARROW_BUS), .BYTE_READY(BYTE_READY), .BUSY(BUSY),
    .DONE(DONE), .ILLEGAL(ILLEGAL), .OP_KIND(OP_KIND), .OP_FIELD(OP_FIELD), .OP_WIDE(OP_WIDE),
    .OP_MEM(OP_MEM), .OP_DIR(OP_DIR), .OP_SEXT(OP_SEXT), .FLAGS_ONLY(FLAGS_ONLY),
    .IMM_VALUE(IMM_VALUE), .SHIFT_COUNT(SHIFT_COUNT), .CYCLES(CYCLES));
  // Clock, 100 ns period
  always #50 CLOCK = ~CLOCK;
  // Cycle count, also the hang limit
  always @(posedge CLOCK) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] s);
    samples_checked++;
    if (x !== s) begin
      $display("Error %s expected %h seen %h", nm, x, s);
      miscompares++;
    end
  endtask
  // Offer one byte, held until an edge sees ready
  task automatic sb(input logic [7:0] b);
    BYTE_VALID = 1'b1;
    BYTE_DATA = b;
    do @(posedge CLOCK); while (BYTE_READY !== 1'b1);
    t_take = cyc_cnt;
    #1;
  endtask
  // Kind 1F means the sequence must be refused; xs bit 16 asks for the attribute check
  task automatic op(input logic [31:0] b, input int nb, input logic [4:0] k,
      input logic [8:0] c, input logic [16:0] im, input logic [16:0] xs = '0);
    for (int i = nb - 1; i >= 0; i--) sb(b[8*i+:8]);
    q.push_back('{k, c, im, t_take, xs});
  endtask
  task automatic idle(input int c);
    BYTE_VALID = 1'b0;
    repeat (c) @(posedge CLOCK);
    #1;
  endtask
  // Monitor: oldest note against each result; pre-edge values are the settled ones
  always @(posedge CLOCK) begin
    if (DONE === 1'b1 || ILLEGAL === 1'b1) begin
      if (q.size() == 0) chk("unexpected result", 16'h0000, 16'h0001);
      else begin
        e = q.pop_front();
        chk("busy", 16'h0000, {15'h0000, BUSY});
        chk("illegal", {15'h0000, e.k == 5'h1F}, {15'h0000, ILLEGAL});
        if (e.k != 5'h1F) begin
          chk("kind", {11'h000, e.k}, {11'h000, OP_KIND});
          chk("cycles", {7'h00, e.c}, {7'h00, CYCLES});
          chk("latency", {7'h00, e.c}, 16'(cyc_cnt - e.t));
          chk("flags_only", {15'h0000, e.k inside {5'h12, 5'h13, 5'h14}}, {15'h0000, FLAGS_ONLY});
          if (e.im[16]) chk("imm", e.im[15:0], IMM_VALUE);
          if (e.xs[16]) chk("attrs", {1'b0, e.xs[14:0]},
            {1'b0, OP_SEXT, OP_DIR, OP_MEM, OP_WIDE, OP_FIELD, SHIFT_COUNT});
        end
      end
    end
  end
  task automatic finish_test();
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence, back-to-back where possible
  initial begin
    void'($urandom(98311));
    repeat (3) @(posedge CLOCK);
    #1 RST = 1'b0;
    op(32'h98, 1, 5'h0A, 9'h002, '0);
    op(32'h99, 1, 5'h0B, 9'h004, '0);
    op(32'hD40A, 2, 5'h08, 9'h013, '0);
    op(32'hD50A, 2, 5'h09, 9'h00F, '0);
    op(32'hD40B, 2, 5'h1F, 9'h000, '0);
    op(32'hF6E8, 2, 5'h04, 9'h01C, '0);
    op(32'hF7E8, 2, 5'h04, 9'h025, '0);
    op(32'hF628, 2, 5'h04, 9'h022, '0);
    op(32'hF728, 2, 5'h04, 9'h02B, '0);
    op(32'h6BC0FF, 3, 5'h05, 9'h019, 17'h1FFFF, {6'b101101, 3'h0, 8'h00});
    op(32'h69003412, 4, 5'h05, 9'h020, 17'h11234);
    op(32'hF6F0, 2, 5'h06, 9'h01D, '0);
    op(32'hF7F0, 2, 5'h06, 9'h026, '0);
    op(32'hF630, 2, 5'h06, 9'h023, '0);
    op(32'hF77055, 3, 5'h06, 9'h02C, '0, {6'b100111, 3'h6, 8'h00});
    op(32'hF6F8, 2, 5'h07, 9'h034, '0);
    op(32'hF7F8, 2, 5'h07, 9'h03D, '0);
    op(32'hF638, 2, 5'h07, 9'h03A, '0);
    op(32'hF738, 2, 5'h07, 9'h043, '0);
    op(32'hF6E0, 2, 5'h03, 9'h01C, '0);
    op(32'hF7E0, 2, 5'h03, 9'h025, '0);
    op(32'hF6D0, 2, 5'h1F, 9'h000, '0);
    for (int f = 0; f < 8; f++) begin
      x = {6'b100001, 3'(f), 8'h01};
      op(16'hD1C0 | 16'(f << 3), 2, f == 6 ? 5'h1F : 5'h0C, 9'h002, '0, x);
    end
    op(32'hD000, 2, 5'h0C, 9'h00F, '0);
    n = $urandom % 64;
    COUNT_LOW = 8'(n);
    op(32'hD2C0, 2, 5'h0D, 9'(5 + n), '0, {6'b100100, 3'h0, 8'(n)});
    op(32'hD338, 2, 5'h0D, 9'(17 + n), '0, {6'b100111, 3'h7, 8'(n)});
    n = $urandom % 64;
    op({16'hC0C0, 8'(n)}, 3, 5'h0E, 9'(5 + n), {9'h100, 8'(n)});
    op(32'h20C0, 2, 5'h0F, 9'h003, '0);
    op(32'h2100, 2, 5'h0F, 9'h00A, '0);
    op(32'h80E012, 3, 5'h10, 9'h004, 17'h10012);
    op(32'h81203412, 4, 5'h10, 9'h010, 17'h11234);
    op(32'h2412, 2, 5'h11, 9'h003, 17'h10012);
    op(32'h253412, 3, 5'h11, 9'h004, 17'h11234);
    op(32'h85C0, 2, 5'h12, 9'h003, '0);
    op(32'hA812, 2, 5'h14, 9'h003, '0);
    op(32'hF6C012, 3, 5'h13, 9'h004, 17'h10012);
    op(32'hF60012, 3, 5'h13, 9'h00A, '0);
    op(32'h0AC0, 2, 5'h15, 9'h003, '0);
    op(32'h80C812, 3, 5'h16, 9'h004, '0);
    op(32'h0D3412, 3, 5'h17, 9'h004, 17'h11234);
    op(32'h80D8, 2, 5'h1F, 9'h000, '0);
    idle(80);
    NARROW_BUS = 1'b1;
    idle(3);
    op(32'hF730, 2, 5'h06, 9'h030, '0);
    op(32'hF630, 2, 5'h06, 9'h023, '0);
    op(32'hF7F0, 2, 5'h06, 9'h026, '0);
    op(32'h81203412, 4, 5'h10, 9'h014, 17'h11234);
    idle(80);
    chk("pending notes", 16'h0000, 16'(q.size()));
    finish_test();
  end
endmodule // aload_decode_tb
